// ==== sadc_pkg.sv ====
// shared constants and types for the converter control and its host end
package sadc_pkg;
	localparam int unsigned RES_BITS      = 16;
	localparam int unsigned CAL_CYCLES    = 14000;
	localparam int unsigned ACQ_GAP       = 3;
	localparam int unsigned ACQ_EDGES     = 4;
	localparam int unsigned CNT_W         = 14;
	localparam int unsigned CLK_MHZ       = 50;
	localparam int unsigned SETTLE_US     = 50;
	localparam int unsigned SETTLE_CYCLES = SETTLE_US * CLK_MHZ;
	localparam int unsigned CLK_DIV       = 16;

	// three-level pin decoded: shutdown, unipolar, bipolar
	typedef enum logic [1:0] {
		SADC_SHDN = 2'b00,
		SADC_UNI  = 2'b01,
		SADC_BIP  = 2'b10
	} sadc_range_t;

	typedef enum logic [1:0] {
		SADC_IDLE = 2'b00,
		SADC_CAL  = 2'b01,
		SADC_CONVERT_START_N = 2'b10,
		SADC_HALT = 2'b11
	} sadc_state_t;
endpackage

// ==== sadc_if.sv ====
// link between the host and the converter control
`timescale 1ns/1ps
interface sadc_if;
	logic convert_start_n_clk;
	logic shift_clk;
	logic convert_start_n;
	logic reset_n;
	logic select_n;
	logic range_drv_o;
	logic range_drv_oe;
	logic eoc;
	logic dout_o;
	logic dout_oe;
	logic range_level;
	logic range_float;
	logic dout_level;

	// three-level pin: floating when the host does not drive it
	assign range_float = !range_drv_oe;
	assign range_level = range_drv_oe & range_drv_o;
	assign dout_level  = dout_oe & dout_o;

	modport dev (
		input  convert_start_n_clk, shift_clk, convert_start_n, reset_n, select_n, range_level, range_float,
		output eoc, dout_o, dout_oe
	);
	modport host (
		output convert_start_n_clk, shift_clk, convert_start_n, reset_n, select_n, range_drv_o, range_drv_oe,
		input  eoc, dout_level
	);
endinterface

// ==== sadc_dev.sv ====
// converter control: calibration, sequencing and serial readout
// What this block does
// - mode pin: low shutdown, high unipolar, floating bipolar
// - shift clock reads result between conversions
// - result leaves most significant bit first
// - end flag high on the same edge as start
// - select low drives output, high releases
// - start on falling edge after acquisition completes
// - reset low holds block inactive
// - reset rising edge starts self calibration
// - calibration lasts 14000 periods, flag high
// - host waits 50 us after shutdown
// - host stops clocks low in shutdown
// - host trusts results after calibration ends
// - each conversion gives sixteen bit code
// - bits readable during or after conversion
// - start pulses ignored while converting
// - start waits four edges after previous end
`timescale 1ns/1ps
module sadc_dev #(
	parameter int unsigned CAL_LEN = sadc_pkg::CAL_CYCLES
) (
	sadc_if.dev                        lnk,
	input  wire logic                  clk,
	input  wire logic                  rst_b,
	input  wire logic [15:0]           sample,
	output logic      [15:0]           result,
	output logic                       result_valid,
	output logic      [1:0]            range_mode,
	output logic                       cal_done
);
	// ----------------------------------------
	// conversion clock domain (falling edges)
	// ----------------------------------------
	sadc_pkg::sadc_state_t state_ff, nxt_state;
	logic [sadc_pkg::CNT_W-1:0] cnt_ff, nxt_cnt;
	logic [1:0]  gap_ff, nxt_gap;
	logic [15:0] sar_ff, nxt_sar;
	logic [15:0] res_ff, nxt_res;
	logic [3:0]  bit_ff, nxt_bit;
	logic        eoc_ff, nxt_eoc;
	logic        pend_ff, nxt_pend;
	logic        rst_s1_ff, rst_s2_ff;
	logic        done_tgl_ff, nxt_done_tgl;
	logic        calok_ff, nxt_calok;
	logic        shdn;

	assign shdn = !lnk.range_float && !lnk.range_level;

	// reset pin is asynchronous to convert_start_n_clk: synchronise before use
	always_ff @(negedge lnk.convert_start_n_clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_s1_ff <= 1'b0;
			rst_s2_ff <= 1'b0;
		end else begin
			rst_s1_ff <= lnk.reset_n;
			rst_s2_ff <= rst_s1_ff;
		end
	end

	always_comb begin
		nxt_state    = state_ff;
		nxt_cnt      = cnt_ff;
		nxt_gap      = gap_ff;
		nxt_sar      = sar_ff;
		nxt_res      = res_ff;
		nxt_bit      = bit_ff;
		nxt_eoc      = 1'b0;
		nxt_pend     = pend_ff;
		nxt_done_tgl = done_tgl_ff;
		nxt_calok    = calok_ff;
		if (!rst_s2_ff || shdn) begin
			nxt_state = sadc_pkg::SADC_HALT;
			nxt_pend  = 1'b0;
		end else begin
			unique case (state_ff)
				sadc_pkg::SADC_HALT: begin
					nxt_state = sadc_pkg::SADC_CAL;
					// flag rises on the edge calibration starts, as for a conversion
					nxt_eoc   = 1'b1;
					nxt_cnt   = '0;
					nxt_calok = 1'b0;
				end
				sadc_pkg::SADC_CAL: begin
					nxt_eoc = 1'b1;
					if (cnt_ff == sadc_pkg::CNT_W'(CAL_LEN - 1)) begin
						nxt_state = sadc_pkg::SADC_IDLE;
						nxt_eoc   = 1'b0;
						nxt_calok = 1'b1;
						nxt_gap   = '0;
					end else begin
						nxt_cnt = cnt_ff + 1'b1;
					end
				end
				sadc_pkg::SADC_IDLE: begin
					if (gap_ff != 2'(sadc_pkg::ACQ_GAP))
						nxt_gap = gap_ff + 1'b1;
					if (!lnk.convert_start_n)
						nxt_pend = 1'b1;
					// acquisition done after the gap: start on this edge
					if ((pend_ff || !lnk.convert_start_n) && gap_ff == 2'(sadc_pkg::ACQ_GAP)) begin
						nxt_state = sadc_pkg::SADC_CONVERT_START_N;
						nxt_pend  = 1'b0;
						nxt_bit   = 4'hf;
						nxt_sar   = '0;
						nxt_eoc   = 1'b1;
					end
				end
				sadc_pkg::SADC_CONVERT_START_N: begin
					// convert_start_n is not looked at here
					nxt_eoc = 1'b1;
					nxt_sar[bit_ff] = sample[bit_ff];
					if (bit_ff == 4'h0) begin
						nxt_state    = sadc_pkg::SADC_IDLE;
						nxt_res      = {sar_ff[15:1], sample[0]};
						nxt_eoc      = 1'b0;
						nxt_gap      = '0;
						nxt_done_tgl = !done_tgl_ff;
					end else begin
						nxt_bit = bit_ff - 1'b1;
					end
				end
			endcase
		end
	end

	always_ff @(negedge lnk.convert_start_n_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_ff    <= sadc_pkg::SADC_HALT;
			cnt_ff      <= '0;
			gap_ff      <= '0;
			sar_ff      <= '0;
			res_ff      <= '0;
			bit_ff      <= '0;
			eoc_ff      <= 1'b0;
			pend_ff     <= 1'b0;
			done_tgl_ff <= 1'b0;
			calok_ff    <= 1'b0;
		end else begin
			state_ff    <= nxt_state;
			cnt_ff      <= nxt_cnt;
			gap_ff      <= nxt_gap;
			sar_ff      <= nxt_sar;
			res_ff      <= nxt_res;
			bit_ff      <= nxt_bit;
			eoc_ff      <= nxt_eoc;
			pend_ff     <= nxt_pend;
			done_tgl_ff <= nxt_done_tgl;
			calok_ff    <= nxt_calok;
		end
	end

	assign lnk.eoc = eoc_ff;

	// ----------------------------------------
	// serial output, shift clock domain
	// ----------------------------------------
	logic [3:0] ptr_ff, nxt_ptr;
	logic [3:0] rd_ptr;
	logic       seen_ff, nxt_seen;
	logic       in_convert_start_n;

	// the shift clock runs only while the host reads, so a synchroniser on it would lag;
	// done_tgl_ff and res_ff change only at the end of a conversion and the host shifts
	// only after eoc has fallen, so both are quiet whenever a shift edge comes
	assign rd_ptr = (seen_ff != done_tgl_ff) ? 4'hf : ptr_ff; // reload msb after a new result

	always_comb begin
		nxt_ptr  = ptr_ff;
		nxt_seen = seen_ff;
		if (!lnk.select_n) begin
			nxt_seen = done_tgl_ff;
			nxt_ptr  = (rd_ptr == 4'h0) ? 4'h0 : rd_ptr - 1'b1;
		end
	end

	always_ff @(negedge lnk.shift_clk or negedge rst_b) begin
		if (!rst_b) begin
			ptr_ff  <= 4'hf;
			seen_ff <= 1'b0;
		end else begin
			ptr_ff  <= nxt_ptr;
			seen_ff <= nxt_seen;
		end
	end

	assign in_convert_start_n = (state_ff == sadc_pkg::SADC_CONVERT_START_N);
	// during conversion the bit decided on the previous edge goes out on the conversion clock
	assign lnk.dout_o  = in_convert_start_n ? sar_ff[4'(bit_ff + 4'h1)] : res_ff[rd_ptr];
	assign lnk.dout_oe = !lnk.select_n;

	// ----------------------------------------
	// user side, system clock
	// ----------------------------------------
	logic ut_s1_ff, ut_s2_ff, ut_s3_ff, cal_s1_ff, cal_s2_ff;
	logic [15:0] result_ff, nxt_result;

	assign nxt_result = (ut_s3_ff != ut_s2_ff) ? res_ff : result_ff;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ut_s1_ff     <= 1'b0;
			ut_s2_ff     <= 1'b0;
			ut_s3_ff     <= 1'b0;
			cal_s1_ff    <= 1'b0;
			cal_s2_ff    <= 1'b0;
			result_ff    <= '0;
			result_valid <= 1'b0;
		end else begin
			ut_s1_ff     <= done_tgl_ff;
			ut_s2_ff     <= ut_s1_ff;
			ut_s3_ff     <= ut_s2_ff;
			cal_s1_ff    <= calok_ff;
			cal_s2_ff    <= cal_s1_ff;
			result_ff    <= nxt_result;
			result_valid <= (ut_s3_ff != ut_s2_ff);
		end
	end

	assign result     = result_ff;
	assign cal_done   = cal_s2_ff;
	assign range_mode = shdn ? 2'b00 : (lnk.range_float ? 2'b10 : 2'b01);
endmodule

// ==== sadc_host.sv ====
// host end: makes both link clocks, drives control pins, reads serial result
`timescale 1ns/1ps
module sadc_host (
	sadc_if.host                       lnk,
	input  wire logic                  clk,
	input  wire logic                  rst_b,
	input  wire logic [1:0]            mode_req,
	input  wire logic                  start_req,
	input  wire logic                  recal_req,
	output logic                       busy,
	output logic      [15:0]           rd_data,
	output logic                       rd_valid,
	output logic                       settled
);
	logic [3:0]  div_ff, nxt_div;
	logic        cclk_ff, nxt_cclk;
	logic        eoc_s1_ff, eoc_s2_ff, eoc_d_ff;
	logic        convert_start_n_n_ff, nxt_convert_start_n_n;
	logic        rstn_ff, nxt_rstn;
	logic        sel_n_ff, nxt_sel_n;
	logic        sclk_ff, nxt_sclk;
	logic [4:0]  nbit_ff, nxt_nbit;
	logic [15:0] sh_ff, nxt_sh;
	logic [15:0] rd_ff, nxt_rd;
	logic        rdv_ff, nxt_rdv;
	logic [11:0] settle_ff, nxt_settle;
	logic        din_s1_ff, din_s2_ff;
	logic [1:0]  park_ff, nxt_park;
	logic        shdn;

	assign shdn = (mode_req == 2'b00);

	always_comb begin
		nxt_div    = div_ff + 1'b1;
		nxt_cclk   = cclk_ff;
		nxt_convert_start_n_n = convert_start_n_n_ff;
		nxt_rstn   = !recal_req;
		nxt_sel_n  = sel_n_ff;
		nxt_sclk   = 1'b0;
		nxt_nbit   = nbit_ff;
		nxt_sh     = sh_ff;
		nxt_rd     = rd_ff;
		nxt_rdv    = 1'b0;
		nxt_park   = shdn ? park_ff : 2'h0;
		nxt_settle = shdn ? '0 : (settle_ff == 12'(sadc_pkg::SETTLE_CYCLES) ? settle_ff : settle_ff + 1'b1);
		if (div_ff == 4'(sadc_pkg::CLK_DIV / 2 - 1)) begin
			nxt_div  = '0;
			// two last falling edges let the device see shutdown before the clock stops low
			nxt_cclk = (shdn && park_ff == 2'h2) ? 1'b0 : !cclk_ff;
			if (shdn && cclk_ff && park_ff != 2'h2)
				nxt_park = park_ff + 1'b1;
		end
		// start only while conversion clock low, released once accepted
		// no start while a read is still shifting, the result would be overwritten
		if (start_req && !cclk_ff && !eoc_s2_ff && sel_n_ff)
			nxt_convert_start_n_n = 1'b0;
		if (eoc_s2_ff)
			nxt_convert_start_n_n = 1'b1;
		// falling end flag: read the sixteen bits with the shift clock
		if (eoc_d_ff && !eoc_s2_ff) begin
			nxt_sel_n = 1'b0;
			nxt_nbit  = 5'h10;
		end
		if (!sel_n_ff && div_ff[1:0] == 2'h3) begin
			if (nbit_ff == 5'h0) begin
				nxt_sel_n = 1'b1;
				nxt_rd    = sh_ff;
				nxt_rdv   = 1'b1;
			end else if (sclk_ff) begin
				nxt_sh   = {sh_ff[14:0], din_s2_ff};
				nxt_nbit = nbit_ff - 1'b1;
			end else begin
				nxt_sclk = 1'b1;
			end
		end else begin
			nxt_sclk = sclk_ff && !sel_n_ff;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			div_ff    <= '0;
			cclk_ff   <= 1'b0;
			eoc_s1_ff <= 1'b0;
			eoc_s2_ff <= 1'b0;
			eoc_d_ff  <= 1'b0;
			din_s1_ff <= 1'b0;
			din_s2_ff <= 1'b0;
			convert_start_n_n_ff <= 1'b1;
			rstn_ff   <= 1'b0;
			sel_n_ff  <= 1'b1;
			sclk_ff   <= 1'b0;
			nbit_ff   <= '0;
			sh_ff     <= '0;
			rd_ff     <= '0;
			rdv_ff    <= 1'b0;
			settle_ff <= '0;
			park_ff   <= '0;
		end else begin
			div_ff    <= nxt_div;
			cclk_ff   <= nxt_cclk;
			eoc_s1_ff <= lnk.eoc;
			eoc_s2_ff <= eoc_s1_ff;
			eoc_d_ff  <= eoc_s2_ff;
			din_s1_ff <= lnk.dout_level;
			din_s2_ff <= din_s1_ff;
			convert_start_n_n_ff <= nxt_convert_start_n_n;
			rstn_ff   <= nxt_rstn;
			sel_n_ff  <= nxt_sel_n;
			sclk_ff   <= nxt_sclk;
			nbit_ff   <= nxt_nbit;
			sh_ff     <= nxt_sh;
			rd_ff     <= nxt_rd;
			rdv_ff    <= nxt_rdv;
			settle_ff <= nxt_settle;
			park_ff   <= nxt_park;
		end
	end

	assign lnk.convert_start_n_clk        = cclk_ff;
	assign lnk.shift_clk       = sclk_ff;
	assign lnk.convert_start_n = convert_start_n_n_ff;
	assign lnk.reset_n         = rstn_ff;
	assign lnk.select_n        = sel_n_ff;
	assign lnk.range_drv_o     = (mode_req == 2'b01);
	assign lnk.range_drv_oe    = (mode_req != 2'b10);
	assign busy     = eoc_s2_ff || !sel_n_ff;
	assign rd_data  = rd_ff;
	assign rd_valid = rdv_ff;
	assign settled  = (settle_ff == 12'(sadc_pkg::SETTLE_CYCLES));
endmodule

// ==== sadc_properties.sv ====
// concurrent checks on the link between host and converter control
`timescale 1ns/1ps
module sadc_properties #(
	parameter int unsigned CAL_LEN = sadc_pkg::CAL_CYCLES
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic convert_start_n_clk,
	input wire logic shift_clk,
	input wire logic convert_start_n,
	input wire logic reset_n,
	input wire logic select_n,
	input wire logic range_level,
	input wire logic range_float,
	input wire logic eoc,
	input wire logic dout_oe
);
	logic        shdn;
	logic [15:0] hi_cnt_ff;
	logic [15:0] nxt_hi_cnt;
	logic [6:0]  park_cnt_ff;
	logic [6:0]  nxt_park_cnt;

	assign shdn = !range_float && !range_level;
	// -----------------------------------------
	// length of the current high stretch of eoc
	// -----------------------------------------
	always_comb begin
		nxt_hi_cnt = eoc ? hi_cnt_ff + 16'h0001 : 16'h0000;
	end
	always_ff @(negedge convert_start_n_clk or negedge rst_b) begin
		if (!rst_b) begin
			hi_cnt_ff <= 16'h0000;
		end else begin
			hi_cnt_ff <= nxt_hi_cnt;
		end
	end
	// -----------------------------------------
	// clock cycles spent in shutdown, saturating
	// -----------------------------------------
	always_comb begin
		nxt_park_cnt = !shdn ? 7'h00 : ((park_cnt_ff == 7'h7f) ? park_cnt_ff : park_cnt_ff + 7'h01);
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			park_cnt_ff <= 7'h00;
		end else begin
			park_cnt_ff <= nxt_park_cnt;
		end
	end
	// -----------------------------------------
	// sequences and assertions
	// -----------------------------------------
	// four idle periods cover the forced acquisition gap
	sequence s_idle;
		(reset_n && !shdn && !eoc)[*4];
	endsequence
	// the host gives a few last edges on entry, so look only after 64 cycles
	sequence s_parked;
		shdn && park_cnt_ff >= 7'h40;
	endsequence
	a_oe_follows_select: assert property (@(posedge clk) disable iff (!rst_b) dout_oe == !select_n)
		else $error("data output enable differs from select");
	a_halt_no_eoc: assert property (@(negedge convert_start_n_clk) disable iff (!rst_b) !reset_n[*4] |-> !eoc)
		else $error("end flag high while held in reset");
	a_cal_after_reset: assert property (@(negedge convert_start_n_clk) disable iff (!rst_b)
		$rose(reset_n) && !shdn |-> ##[1:4] eoc)
		else $error("no calibration after reset release");
	a_eoc_held: assert property (@(negedge convert_start_n_clk) disable iff (!rst_b) $rose(eoc) |-> eoc[*8])
		else $error("end flag dropped early");
	a_eoc_length: assert property (@(negedge convert_start_n_clk) disable iff (!rst_b)
		$fell(eoc) && reset_n && !shdn |-> hi_cnt_ff == 16'h0010 || hi_cnt_ff == CAL_LEN)
		else $error("end flag high for a wrong number of periods");
	a_end_gap: assert property (@(negedge convert_start_n_clk) disable iff (!rst_b) $fell(eoc) |-> !eoc[*3])
		else $error("conversion started inside acquisition gap");
	a_start_prompt: assert property (@(negedge convert_start_n_clk) disable iff (!rst_b)
		s_idle ##0 !convert_start_n |-> ##[1:2] eoc)
		else $error("conversion did not start promptly");
	a_clocks_parked: assert property (@(posedge clk) disable iff (!rst_b) s_parked |-> !convert_start_n_clk && !shift_clk)
		else $error("link clocks running in shutdown");
endmodule

// ==== sadc_bench.sv ====
// self-checking bench: host and converter control joined over the link
`timescale 1ns/1ps
module sadc_bench;
	localparam int unsigned CAL_LEN = 20;
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic [15:0] sample = 16'h0000;
	logic [1:0]  mode_req = 2'h1;
	logic        start_req = 1'b0;
	logic        recal_req = 1'b0;
	logic [15:0] result;
	logic        result_valid;
	logic [1:0]  range_mode;
	logic        cal_done;
	logic        busy;
	logic [15:0] rd_data;
	logic        rd_valid;
	logic        settled;
	logic [15:0] wire_word = 16'h0000;
	int          mismatches = 0;
	int          samples_checked = 0;

	sadc_if lnk ();
	always #10 clk = ~clk;
	sadc_dev #(.CAL_LEN(CAL_LEN)) sadc_dev_inst (.lnk(lnk), .clk(clk), .rst_b(rst_b), .sample(sample),
		.result(result), .result_valid(result_valid), .range_mode(range_mode), .cal_done(cal_done));
	sadc_host sadc_host_inst (.lnk(lnk), .clk(clk), .rst_b(rst_b), .mode_req(mode_req), .start_req(start_req),
		.recal_req(recal_req), .busy(busy), .rd_data(rd_data), .rd_valid(rd_valid), .settled(settled));
	sadc_properties #(.CAL_LEN(CAL_LEN)) sadc_properties_inst (.clk(clk), .rst_b(rst_b),
		.convert_start_n_clk(lnk.convert_start_n_clk), .shift_clk(lnk.shift_clk), .convert_start_n(lnk.convert_start_n),
		.reset_n(lnk.reset_n), .select_n(lnk.select_n), .range_level(lnk.range_level),
		.range_float(lnk.range_float), .eoc(lnk.eoc), .dout_oe(lnk.dout_oe));
	// wire bits taken where the shift clock rises, oldest bit ends up on top
	always @(posedge lnk.shift_clk) begin
		if (lnk.select_n === 1'b0) begin
			wire_word <= {wire_word[14:0], lnk.dout_level};
		end
	end
	// -----------------------------------------
	// shared tasks
	// -----------------------------------------
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %h, seen %h", name, exp, seen);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d, mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	function automatic logic pick(input int which);
		case (which)
			0: return lnk.eoc;
			1: return rd_valid;
			2: return cal_done;
			default: return settled;
		endcase
	endfunction
	// bounded wait, sampled away from the launching edge
	task automatic wait_for(input int which, input logic level);
		int i;
		for (i = 0; i < 4000 && pick(which) !== level; i++) begin
			@(negedge clk);
		end
		if (pick(which) !== level) begin
			mismatches++;
			$display("unexpected wait %0d: expected %b, seen %b", which, level, pick(which));
			finish_test();
		end
	endtask
	// -----------------------------------------
	// scenarios
	// -----------------------------------------
	task automatic t_calibrate();
		wait_for(0, 1'b1);
		wait_for(2, 1'b1);
		check("eoc after calibration", lnk.eoc, 1'b0);
		check("range after reset", range_mode, 2'h1);
		$display("test calibrate done");
	endtask
	// start is held well into the conversion, which must not stretch it
	task automatic t_convert(input logic [15:0] v);
		@(posedge clk);
		sample <= v;
		start_req <= 1'b1;
		wait_for(0, 1'b1);
		repeat (20) @(posedge clk);
		start_req <= 1'b0;
		wait_for(1, 1'b1);
		check("read data", rd_data, v);
		check("result", result, v);
		check("wire bits", wire_word, v);
		repeat (10) @(negedge clk);
		check("output enable idle", lnk.dout_oe, 1'b0);
		check("data line idle", lnk.dout_level, 1'b0);
		$display("test convert %h done", v);
	endtask
	task automatic t_modes();
		logic [1:0] m;
		for (int i = 0; i < 3; i++) begin
			m = (i == 0) ? 2'h2 : (i == 1) ? 2'h0 : 2'h1;
			@(posedge clk);
			mode_req <= m;
			repeat (100) @(negedge clk);
			check("range mode", range_mode, m);
			check("range float", lnk.range_float, m == 2'h2);
			if (i == 0) begin
				t_convert(16'h8001);
			end
		end
		check("eoc after leaving shutdown", lnk.eoc, 1'b1);
		check("settled early", settled, 1'b0);
		wait_for(3, 1'b1);
		check("calibrated", cal_done, 1'b1);
		$display("test modes done");
	endtask
	task automatic t_recal();
		@(posedge clk);
		recal_req <= 1'b1;
		repeat (200) @(negedge clk);
		check("reset line", lnk.reset_n, 1'b0);
		check("eoc in reset", lnk.eoc, 1'b0);
		@(posedge clk);
		recal_req <= 1'b0;
		wait_for(0, 1'b1);
		wait_for(0, 1'b0);
		// cal_done crosses two flip-flops after the flag falls
		repeat (4) @(negedge clk);
		check("calibrated again", cal_done, 1'b1);
		$display("test recal done");
	endtask
	initial begin
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		t_calibrate();
		t_convert(16'hffff);
		t_convert(16'h5a3c);
		t_convert(16'h0000);
		t_modes();
		t_convert(16'h0001);
		t_recal();
		t_convert(16'hc3a5);
		finish_test();
	end
endmodule
